// >>> sps_consts.vh
// constants for the step profile sequencer: register map, field codes,
// reset values and timing figures
// assumes it is included by its bare name from each design file
`ifndef SPS_CONSTS_VH
`define SPS_CONSTS_VH

// register byte offsets, haddr[11:0]
`define SPS_OFS_SRC 12'h000
`define SPS_OFS_DIN 12'h004
`define SPS_OFS_OUT 12'h008
`define SPS_OFS_STAT 12'h010
`define SPS_OFS_ELAPSED 12'h014
`define SPS_BASE_WORD 12'h020
`define SPS_BASE_TIME 12'h040
`define SPS_BASE_SPEED 12'h060

// reset values and the elapsed count limit
`define SPS_WORD_RST 16'h00F1
`define SPS_TIME_RST 14'h012C
`define SPS_TIME_MAX 14'h3FFF

// selection codes
`define SPS_SRC_STEP 8'h06
`define SPS_DIN_SEQ_A 8'h17
`define SPS_DIN_SEQ_B 8'h18
`define SPS_OUT_SEQ 8'h0F

// condition codes for digits 0 and 1
`define SPS_C_IMM 4'h0
`define SPS_C_TIME 4'h1
`define SPS_C_A 4'h2
`define SPS_C_B 4'h3
`define SPS_C_NA 4'h4
`define SPS_C_NB 4'h5
`define SPS_C_AORB 4'h6
`define SPS_C_AANDB 4'h7
`define SPS_C_NONE 4'h8
`define SPS_C_ANB 4'h9
`define SPS_C_BNA 4'hA
`define SPS_C_TA 4'hB
`define SPS_C_TB 4'hC
`define SPS_C_TNA 4'hD
`define SPS_C_TNB 4'hE
`define SPS_C_NEVER 4'hF

// digit 2 end actions
`define SPS_J_NSTOP 4'h8
`define SPS_J_COAST 4'h9
`define SPS_J_FAULT 4'hA

// timing: one tenth of a second, in microseconds, at the clock rate
`define SPS_TICK_US 100000
`define SPS_CLK_MHZ 125

// sequencer states
`define SPS_ST_IDLE 2'h0
`define SPS_ST_RUN 2'h1
`define SPS_ST_DONE 2'h2

`endif

// >>> sps_cond.v
// condition decoder for one step-word digit (digit 0 or digit 1)
// assumes synchronised logic inputs and a time-done flag on the same clock
`timescale 1ns/100ps
`include "sps_consts.vh"

module sps_cond (
  // condition selection
  input wire [3:0] code,
  // qualifiers
  input wire time_done,
  input wire in_a,
  input wire in_b,
  // result
  output reg met
);

  // one decode per code; never-step gives no condition at all
  always @* begin
    case (code)
      `SPS_C_IMM: met = 1'b1;
      `SPS_C_TIME: met = time_done;
      `SPS_C_A: met = in_a;
      `SPS_C_B: met = in_b;
      `SPS_C_NA: met = ~in_a;
      `SPS_C_NB: met = ~in_b;
      `SPS_C_AORB: met = in_a | in_b;
      `SPS_C_AANDB: met = in_a & in_b;
      `SPS_C_NONE: met = ~(in_a | in_b);
      `SPS_C_ANB: met = in_a & ~in_b;
      `SPS_C_BNA: met = in_b & ~in_a;
      `SPS_C_TA: met = time_done & in_a;
      `SPS_C_TB: met = time_done & in_b;
      `SPS_C_TNA: met = time_done & ~in_a;
      `SPS_C_TNB: met = time_done & ~in_b;
      `SPS_C_NEVER: met = 1'b0;
      default: met = 1'b0;
    endcase
  end

endmodule // sps_cond

// >>> sps_top.v
// step profile sequencer: eight programmable steps, AHB-Lite register file
// assumes a single-slave AHB-Lite bus on hclk and pins from outside the domain
// Operation
// - runs only when speed source is code 6
// - starts on run command, always at step 0
// - leave step on time, input, or both
// - input codes 23/24 make inputs A/B
// - step time used only by codes 1,b,C,d,E
// - step n commands preset speed n
// - digit 0 met advances, 7 wraps to 0
// - digit 0 code 3 steps on input B
// - digit 1 met overrides, jumps to digit 2
// - digit 2 picks target step or end action
// - digit 3 picks ramp set and direction
// - output code 15 follows digit 3 state
// - one common sequencer output for all steps
// - digit 2: 0-7 step, 8 stop, 9 coast, A fault
// - codes 0 now, 1 timed, F never
// - step time 0.0-999.9 s, default 30.0
`timescale 1ns/100ps
`include "sps_consts.vh"

module sps_top #(
  parameter N_IN = 4,
  parameter TICK_W = 24,
  parameter TICK_CYCLES = `SPS_TICK_US * `SPS_CLK_MHZ
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // pins from the drive
  input wire run_cmd,
  input wire [N_IN-1:0] din,
  // speed ramp control
  output reg [15:0] speed_ref_q,
  output reg ramp2_q,
  output reg dir_rev_q,
  output reg dir_none_q,
  output reg seq_active_q,
  output reg end_normal_q,
  output reg end_coast_q,
  output reg end_fault_q,
  // relay and opto outputs
  output reg relay_out_q,
  output reg opto1_out_q,
  output reg opto2_out_q
);

  // the subtraction is 32 bits wide; cut it to the prescaler width on purpose
  localparam integer TICK_LAST_I = TICK_CYCLES - 1;
  localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_I[TICK_W-1:0];

  // ****************************************************************
  // input synchronisers
  // ****************************************************************

  reg [N_IN:0] sync1_q;
  reg [N_IN:0] sync2_q;

  // run and digital inputs come from pins: two flops before any logic
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= {(N_IN+1){1'b0}};
      sync2_q <= {(N_IN+1){1'b0}};
    end else begin
      sync1_q <= {run_cmd, din};
      sync2_q <= sync1_q;
    end
  end

  wire run_s = sync2_q[N_IN];
  wire [N_IN-1:0] din_s = sync2_q[N_IN-1:0];

  // ****************************************************************
  // register file
  // ****************************************************************

  reg [7:0] speed_source_param_q;
  reg [31:0] input_select_params_q;
  reg [7:0] relay_select_param_q;
  reg [7:0] opto1_select_param_q;
  reg [7:0] opto2_select_param_q;
  reg [15:0] step_word_params_q [0:7];
  reg [13:0] step_time_params_q [0:7];
  reg [15:0] preset_speed_params_q [0:7];

  // ahb address phase capture
  reg wr_pend_q;
  reg rd_pend_q;
  reg [11:0] addr_q;
  wire take = hsel & htrans[1] & hready;
  integer i;

  // reads take one wait state so read data comes straight from a flop
  assign hreadyout = ~rd_pend_q;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      if (hready) begin
        wr_pend_q <= take & hwrite;
        rd_pend_q <= take & ~hwrite;
        addr_q <= {haddr[11:2], 2'b00};
      end else begin
        wr_pend_q <= 1'b0;
        rd_pend_q <= 1'b0;
      end
    end
  end

  wire [2:0] widx = addr_q[4:2];
  wire [11:0] wbase = {addr_q[11:5], 5'h00};

  // write data phase; unmapped offsets are ignored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_source_param_q <= 8'h00;
      input_select_params_q <= 32'h00000000;
      relay_select_param_q <= 8'h00;
      opto1_select_param_q <= 8'h00;
      opto2_select_param_q <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        step_word_params_q[i] <= `SPS_WORD_RST;
        step_time_params_q[i] <= `SPS_TIME_RST;
        preset_speed_params_q[i] <= 16'h0000;
      end
    end else if (wr_pend_q) begin
      if (addr_q == `SPS_OFS_SRC) begin
        speed_source_param_q <= hwdata[7:0];
      end
      if (addr_q == `SPS_OFS_DIN) begin
        input_select_params_q <= hwdata;
      end
      if (addr_q == `SPS_OFS_OUT) begin
        relay_select_param_q <= hwdata[7:0];
        opto1_select_param_q <= hwdata[15:8];
        opto2_select_param_q <= hwdata[23:16];
      end
      // words hold all four digits as written
      if (wbase == `SPS_BASE_WORD) begin
        step_word_params_q[widx] <= hwdata[15:0];
      end
      // tenths of a second, clamped to the top of the range
      if (wbase == `SPS_BASE_TIME) begin
        if (hwdata[15:0] > 16'h270F) begin
          step_time_params_q[widx] <= 14'h270F;
        end else begin
          step_time_params_q[widx] <= hwdata[13:0];
        end
      end
      if (wbase == `SPS_BASE_SPEED) begin
        preset_speed_params_q[widx] <= hwdata[15:0];
      end
    end
  end

  // ****************************************************************
  // sequencer logic inputs
  // ****************************************************************

  reg seq_input_a;
  reg seq_input_b;
  integer k;

  // any digital input whose selection names input A or B drives it
  always @* begin
    seq_input_a = 1'b0;
    seq_input_b = 1'b0;
    for (k = 0; k < N_IN; k = k + 1) begin
      if (input_select_params_q[8*k +: 8] == `SPS_DIN_SEQ_A) begin
        seq_input_a = seq_input_a | din_s[k];
      end
      if (input_select_params_q[8*k +: 8] == `SPS_DIN_SEQ_B) begin
        seq_input_b = seq_input_b | din_s[k];
      end
    end
  end

  // ****************************************************************
  // step timer
  // ****************************************************************

  reg [1:0] state_q;
  reg [2:0] step_q;
  reg [TICK_W-1:0] pre_q;
  reg [13:0] elapsed_q;
  reg entry;

  wire [15:0] word = step_word_params_q[step_q];
  wire [3:0] dig0 = word[3:0];
  wire [3:0] dig1 = word[7:4];
  wire [3:0] dig2 = word[11:8];
  wire [3:0] dig3 = word[15:12];
  // only timed codes look at this flag, so the time acts only for them
  wire time_done = elapsed_q >= step_time_params_q[step_q];

  // counts tenths; cleared on every entry so a jump to itself retimes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= {TICK_W{1'b0}};
      elapsed_q <= 14'h0000;
    end else if (entry || state_q != `SPS_ST_RUN) begin
      pre_q <= {TICK_W{1'b0}};
      elapsed_q <= 14'h0000;
    end else if (pre_q == TICK_LAST) begin
      pre_q <= {TICK_W{1'b0}};
      if (elapsed_q != `SPS_TIME_MAX) begin
        elapsed_q <= elapsed_q + 14'h0001;
      end
    end else begin
      pre_q <= pre_q + {{(TICK_W-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************************************
  // step conditions
  // ****************************************************************

  wire next_met;
  wire jump_met;

  // digit 0: logic for next step
  sps_cond u_next (
    .code(dig0),
    .time_done(time_done),
    .in_a(seq_input_a),
    .in_b(seq_input_b),
    .met(next_met)
  );

  // digit 1: logic for a jump
  sps_cond u_jump (
    .code(dig1),
    .time_done(time_done),
    .in_a(seq_input_a),
    .in_b(seq_input_b),
    .met(jump_met)
  );

  // ****************************************************************
  // sequencer state machine
  // ****************************************************************

  reg [1:0] state_d;
  reg [2:0] step_d;
  reg [2:0] end_d;
  wire mode_ok = speed_source_param_q == `SPS_SRC_STEP;

  // conditions are looked at on every clock while running
  always @* begin
    state_d = state_q;
    step_d = step_q;
    end_d = {end_fault_q, end_coast_q, end_normal_q};
    entry = 1'b0;
    case (state_q)
      `SPS_ST_IDLE: begin
        end_d = 3'b000;
        if (run_s && mode_ok) begin
          state_d = `SPS_ST_RUN;
          step_d = 3'h0;
          entry = 1'b1;
        end
      end
      `SPS_ST_RUN: begin
        if (!run_s || !mode_ok) begin
          state_d = `SPS_ST_IDLE;
          step_d = 3'h0;
        end else if (jump_met && dig1 != `SPS_C_NEVER) begin
          // jump wins over a met digit 0
          if (dig2 <= 4'h7) begin
            step_d = dig2[2:0];
            entry = 1'b1;
          end else if (dig2 == `SPS_J_NSTOP) begin
            state_d = `SPS_ST_DONE;
            end_d = 3'b001;
          end else if (dig2 == `SPS_J_COAST) begin
            state_d = `SPS_ST_DONE;
            end_d = 3'b010;
          end else if (dig2 == `SPS_J_FAULT) begin
            state_d = `SPS_ST_DONE;
            end_d = 3'b100;
          end
        end else if (next_met) begin
          step_d = step_q + 3'h1;
          entry = 1'b1;
        end
      end
      `SPS_ST_DONE: begin
        // ended programs wait for the run command to drop
        if (!run_s) begin
          state_d = `SPS_ST_IDLE;
          step_d = 3'h0;
        end
      end
      default: begin
        state_d = `SPS_ST_IDLE;
        step_d = 3'h0;
      end
    endcase
  end

  // ****************************************************************
  // step settings to the drive
  // ****************************************************************

  reg seq_out_d;
  reg ramp2_d;
  reg dir_rev_d;
  reg dir_none_d;

  // digit 3 codes: three directions per output state per ramp set
  always @* begin
    ramp2_d = dig3 >= 4'h6;
    seq_out_d = (dig3 >= 4'h3 && dig3 <= 4'h5) || (dig3 >= 4'h9 && dig3 <= 4'hB);
    dir_rev_d = dig3 == 4'h1 || dig3 == 4'h4 || dig3 == 4'h7 || dig3 == 4'hA;
    dir_none_d = dig3 == 4'h2 || dig3 == 4'h5 || dig3 == 4'h8 || dig3 == 4'hB;
    if (dig3 > 4'hB) begin
      ramp2_d = 1'b0;
      seq_out_d = 1'b0;
      dir_rev_d = 1'b0;
      dir_none_d = 1'b1;
    end
  end

  wire run_now = state_q == `SPS_ST_RUN;
  // a single sequencer output; every selected pin shows the same state
  wire seq_out = run_now & seq_out_d;

  // state and registered outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= `SPS_ST_IDLE;
      step_q <= 3'h0;
      end_normal_q <= 1'b0;
      end_coast_q <= 1'b0;
      end_fault_q <= 1'b0;
      speed_ref_q <= 16'h0000;
      ramp2_q <= 1'b0;
      dir_rev_q <= 1'b0;
      dir_none_q <= 1'b1;
      seq_active_q <= 1'b0;
      relay_out_q <= 1'b0;
      opto1_out_q <= 1'b0;
      opto2_out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      end_normal_q <= end_d[0];
      end_coast_q <= end_d[1];
      end_fault_q <= end_d[2];
      seq_active_q <= run_now;
      speed_ref_q <= run_now ? preset_speed_params_q[step_q] : 16'h0000;
      ramp2_q <= run_now & ramp2_d;
      dir_rev_q <= run_now & dir_rev_d;
      dir_none_q <= ~run_now | dir_none_d;
      relay_out_q <= seq_out & (relay_select_param_q == `SPS_OUT_SEQ);
      opto1_out_q <= seq_out & (opto1_select_param_q == `SPS_OUT_SEQ);
      opto2_out_q <= seq_out & (opto2_select_param_q == `SPS_OUT_SEQ);
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************

  reg [31:0] rdata;

  // status gathers the live sequencer state for software
  always @* begin
    rdata = 32'h00000000;
    if (addr_q == `SPS_OFS_SRC) begin
      rdata = {24'h000000, speed_source_param_q};
    end
    if (addr_q == `SPS_OFS_DIN) begin
      rdata = input_select_params_q;
    end
    if (addr_q == `SPS_OFS_OUT) begin
      rdata = {8'h00, opto2_select_param_q, opto1_select_param_q, relay_select_param_q};
    end
    if (addr_q == `SPS_OFS_STAT) begin
      rdata = {18'h00000, end_fault_q, end_coast_q, end_normal_q, seq_input_b, seq_input_a,
               dir_none_q, dir_rev_q, ramp2_q, seq_out, state_q, step_q};
    end
    if (addr_q == `SPS_OFS_ELAPSED) begin
      rdata = {18'h00000, elapsed_q};
    end
    if (wbase == `SPS_BASE_WORD) begin
      rdata = {16'h0000, step_word_params_q[widx]};
    end
    if (wbase == `SPS_BASE_TIME) begin
      rdata = {18'h00000, step_time_params_q[widx]};
    end
    if (wbase == `SPS_BASE_SPEED) begin
      rdata = {16'h0000, preset_speed_params_q[widx]};
    end
  end

  // read data is loaded in the wait cycle and held until the next read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_q) begin
      hrdata <= rdata;
    end
  end

endmodule // sps_top

// >>> sps_top_properties.sv
// assertion checker for the step sequencer top level
// assumes it is bound to sps_top and sees only its ports
`timescale 1ns/100ps
// ****************************************
// checker
// ****************************************
module sps_top_properties #(
  parameter N_IN = 4
) (
  // clock, reset and bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // pins
  input wire run_cmd,
  input wire [N_IN-1:0] din,
  // drive outputs
  input wire [15:0] speed_ref_q,
  input wire ramp2_q,
  input wire dir_rev_q,
  input wire dir_none_q,
  input wire seq_active_q,
  input wire end_normal_q,
  input wire end_coast_q,
  input wire end_fault_q,
  input wire relay_out_q,
  input wire opto1_out_q,
  input wire opto2_out_q
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // accepted transfers, split by direction
  wire rd_take = hsel && htrans[1] && hready && !hwrite;
  wire wr_take = hsel && htrans[1] && hready && hwrite;
  wire [2:0] ends = {end_normal_q, end_coast_q, end_fault_q};
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  AST_READ_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  AST_WRITE_NOWAIT: assert property (wr_take |=> hreadyout)
    else $error("write data phase stalled");
  AST_HRDATA_HOLD: assert property (!$past(rd_take) && !$past(rd_take, 2) |-> $stable(hrdata))
    else $error("read data changed without a read");
  // eight low samples cover the synchroniser, state and output stages
  AST_IDLE_OUTPUTS: assert property (!run_cmd [*8] |-> dir_none_q && !ramp2_q && speed_ref_q == 16'h0000
    && !relay_out_q && !opto1_out_q && !opto2_out_q && !seq_active_q && ends == 3'h0)
    else $error("outputs not idle after run removal");
  AST_END_HELD: assert property (run_cmd [*5] ##0 ends != 3'h0 |=> $stable(ends))
    else $error("end flag dropped while run held");
  AST_END_ONEHOT: assert property ($onehot0(ends))
    else $error("more than one end action flagged");
  AST_DIR_EXCL: assert property (dir_rev_q |-> !dir_none_q)
    else $error("reverse and no direction together");
  cover property ($rose(seq_active_q));
  cover property ($rose(end_fault_q));
  cover property (rd_take ##2 hreadyout);
endmodule // sps_top_properties

bind sps_top sps_top_properties #(.N_IN(N_IN)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .run_cmd(run_cmd), .din(din), .speed_ref_q(speed_ref_q), .ramp2_q(ramp2_q),
  .dir_rev_q(dir_rev_q), .dir_none_q(dir_none_q), .seq_active_q(seq_active_q),
  .end_normal_q(end_normal_q), .end_coast_q(end_coast_q), .end_fault_q(end_fault_q),
  .relay_out_q(relay_out_q), .opto1_out_q(opto1_out_q), .opto2_out_q(opto2_out_q)
);

// >>> sps_drive_model.sv
// drive-side model: run command and logic-input pins
// assumes bench requests change just after a rising hclk edge
`timescale 1ns/100ps
// ****************************************
// drive model
// ****************************************
module sps_drive_model (
  // clock
  input wire hclk,
  // requests from the bench
  input wire run_req,
  input wire a_req,
  input wire b_req,
  // pins toward the sequencer
  output reg run_cmd,
  output reg [3:0] din
);
  reg [1:0] spare_q;
  initial begin
    run_cmd = 1'b0;
    din = 4'h0;
    spare_q = 2'h0;
  end
  // unselected pins carry a two-bit count that steps every cycle so a wrong input decode shows
  always @(posedge hclk) begin
    spare_q <= spare_q + 2'h1;
    run_cmd <= run_req;
    din <= {spare_q, b_req, a_req};
  end
endmodule // sps_drive_model

// >>> test_step_profile_sequencer.sv
// testbench for the step sequencer: bus tasks and step scenarios
// assumes sps_top, its checker and the drive model are compiled first
`timescale 1ns/100ps
module test_step_profile_sequencer;
  reg hclk, hresetn, hsel, hwrite, run_req, a_req, b_req;
  reg [31:0] haddr, hwdata, rdat;
  reg [1:0] htrans;
  reg [2:0] hsize;
  wire hreadyout, hresp, run_cmd, ramp2_q, dir_rev_q, dir_none_q, seq_active_q;
  wire end_normal_q, end_coast_q, end_fault_q, relay_out_q, opto1_out_q, opto2_out_q;
  wire [31:0] hrdata;
  wire [3:0] din;
  wire [15:0] speed_ref_q;
  integer miscompares, samples_checked, k;
  // short tick keeps timed steps to tens of cycles
  sps_top #(.N_IN(4), .TICK_W(24), .TICK_CYCLES(10)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .run_cmd(run_cmd), .din(din), .speed_ref_q(speed_ref_q), .ramp2_q(ramp2_q),
    .dir_rev_q(dir_rev_q), .dir_none_q(dir_none_q), .seq_active_q(seq_active_q),
    .end_normal_q(end_normal_q), .end_coast_q(end_coast_q), .end_fault_q(end_fault_q),
    .relay_out_q(relay_out_q), .opto1_out_q(opto1_out_q), .opto2_out_q(opto2_out_q));
  sps_drive_model u_drive (.hclk(hclk), .run_req(run_req), .a_req(a_req), .b_req(b_req),
    .run_cmd(run_cmd), .din(din));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // ****************************************
  // bench tasks
  // ****************************************
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one ahb-lite single transfer; hready is sampled, never assumed
  task xfer(input wr, input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      rdat = hrdata;
    end
  endtask
  task rd(input [31:0] a, input [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0);
      chk(rdat, exp);
    end
  endtask
  // poll each cycle so a one-cycle step is still seen
  task wait_speed(input [15:0] exp);
    integer n;
    begin
      n = 0;
      while (speed_ref_q !== exp && n < 200) begin
        @(posedge hclk);
        n = n + 1;
      end
      chk({16'h0, speed_ref_q}, {16'h0, exp});
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    miscompares = 0;
    samples_checked = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rdat = 32'h0;
    run_req = 1'b0;
    a_req = 1'b0;
    b_req = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h020, 32'h00F1);
    rd(32'h040, 32'h012C);
    rd(32'h0FC, 32'h0);
    xfer(1'b1, 32'h040, 32'h3FFF);
    rd(32'h040, 32'h270F);
    // run without the step source selected
    run_req <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({31'h0, seq_active_q}, 32'h0);
    run_req <= 1'b0;
    repeat (6) @(posedge hclk);
    for (k = 0; k < 8; k = k + 1) xfer(1'b1, 32'h060 + 4 * k, 32'h0100 + k);
    xfer(1'b1, 32'h004, 32'h1817);
    xfer(1'b1, 32'h008, 32'h000F);
    xfer(1'b1, 32'h020, 32'h40F3);
    xfer(1'b1, 32'h024, 32'h70F1);
    xfer(1'b1, 32'h044, 32'h0002);
    xfer(1'b1, 32'h028, 32'h072F);
    xfer(1'b1, 32'h03C, 32'h00F0);
    xfer(1'b1, 32'h000, 32'h0006);
    run_req <= 1'b1;
    wait_speed(16'h0100);
    chk({29'h0, dir_rev_q, ramp2_q, relay_out_q}, 32'h5);
    chk({30'h0, opto2_out_q, opto1_out_q}, 32'h0);
    chk({31'h0, seq_active_q}, 32'h1);
    rd(32'h010, 32'h000000A8);
    repeat (20) @(posedge hclk);
    chk({16'h0, speed_ref_q}, 32'h0100);
    b_req <= 1'b1;
    wait_speed(16'h0101);
    chk({29'h0, dir_rev_q, ramp2_q, relay_out_q}, 32'h6);
    b_req <= 1'b0;
    repeat (10) @(posedge hclk);
    chk({16'h0, speed_ref_q}, 32'h0101);
    wait_speed(16'h0102);
    a_req <= 1'b1;
    wait_speed(16'h0107);
    wait_speed(16'h0100);
    a_req <= 1'b0;
    repeat (20) @(posedge hclk);
    chk({16'h0, speed_ref_q}, 32'h0100);
    run_req <= 1'b0;
    repeat (8) @(posedge hclk);
    chk({15'h0, dir_none_q, speed_ref_q}, 32'h10000);
    // immediate jump from step 0 into each end action
    for (k = 8; k < 11; k = k + 1) begin
      xfer(1'b1, 32'h020, {20'h0, k[3:0], 8'h00});
      run_req <= 1'b1;
      repeat (12) @(posedge hclk);
      chk({29'h0, end_normal_q, end_coast_q, end_fault_q}, 32'h1 << (10 - k));
      run_req <= 1'b0;
      repeat (8) @(posedge hclk);
      chk({29'h0, end_normal_q, end_coast_q, end_fault_q}, 32'h0);
    end
    report_and_stop;
  end
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule // test_step_profile_sequencer
